// [hw/trigger_sequencer.sv]
// Trigger sequencer with AXI4-Lite register access.
`default_nettype none
module trigger_sequencer
  import trigger_sequencer_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read channels.
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // External trigger pin and measurement path handshake.
  input wire logic ext_trig_in,
  input wire logic reading_done,
  output logic reading_start,
  output logic meter_complete_out,
  output logic buffer_write,
  // Front panel indicators.
  output logic waiting_indicator,
  output logic triggered_indicator,
  // Filter controls.
  output logic analog_filter_en,
  output logic [1:0] digital_resp,
  output logic digital_select_req
);
  localparam int TW = $clog2(TICK_CYCLES_P + 1);

  logic aw_got;
  logic w_got;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic wr_mapped;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] wr_masked;
  logic [CTRL_W-1:0] ctrl_word;
  logic [CTRL_W-1:0] next_ctrl;
  logic [DATA_W-1:0] cmd_bits;
  logic [CNT_W-1:0] ivl_entry;
  logic [CNT_W-1:0] ivl_active;
  logic [CNT_W-1:0] dly_entry;
  logic [CNT_W-1:0] dly_active;
  logic [CNT_W-1:0] dly_cnt;
  logic [CNT_W-1:0] ivl_cnt;
  logic [CNT_W-1:0] flash_cnt;
  logic flash_phase;
  logic [TW-1:0] tick_div;
  logic tick;
  logic [STICKY_N-1:0] sticky;
  logic [STICKY_N-1:0] sticky_set;
  logic [STICKY_N-1:0] sticky_clr;
  logic ivl_err_set;
  logic sel_req_set;
  logic src_chg;
  logic ext_sync1;
  logic ext_sync2;
  logic ext_prev;
  logic ext_fall;
  logic src_evt;
  logic trig;
  logic overrun_set;
  logic start_now;
  logic one_shot;
  trig_src_e src;
  seq_state_e state;
  logic [DATA_W-1:0] rd_word;
  logic rd_ok;

  // Byte lanes of the write strobe widened to a bit mask.
  assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  assign wr_masked = wr_data & wmask;

  // Address and data may arrive in either order; the write acts once both are held.
  assign wr_fire = aw_got & w_got & ~bvalid;
  assign wr_mapped = (wr_addr == REG_CTRL) | (wr_addr == REG_IVL_ENTRY) | (wr_addr == REG_DLY_ENTRY)
                   | (wr_addr == REG_CMD) | (wr_addr == REG_STATUS);

  // Write channel handshake and response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      if (awvalid && awready) begin
        wr_addr <= awaddr;
        aw_got <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
        w_got <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Command bits only live for the write cycle, so they need no clearing.
  assign cmd_bits = (wr_fire && wr_addr == REG_CMD) ? wr_masked : '0;
  assign next_ctrl = (ctrl_word & ~wmask[CTRL_W-1:0]) | wr_masked[CTRL_W-1:0];
  assign one_shot = ~ctrl_word[CTRL_MODE_BIT];
  assign src = trig_src_e'(ctrl_word[CTRL_SRC_LSB +: 3]);

  // Control word; a source change and a filter switch-on with both filters off are flagged.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_word <= CTRL_RESET;
      src_chg <= 1'b0;
      sel_req_set <= 1'b0;
    end else begin
      src_chg <= 1'b0;
      sel_req_set <= 1'b0;
      if (wr_fire && wr_addr == REG_CTRL) begin
        ctrl_word <= next_ctrl;
        src_chg <= next_ctrl[CTRL_SRC_LSB +: 3] != ctrl_word[CTRL_SRC_LSB +: 3];
        sel_req_set <= next_ctrl[CTRL_FILT_BIT] & ~ctrl_word[CTRL_FILT_BIT] & ~next_ctrl[CTRL_ANA_BIT]
                     & (next_ctrl[CTRL_RESP_LSB +: 2] == RESP_OFF);
      end
    end
  end

  // Filter enables follow the master switch; stored selections only matter while it is on.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_filter_en <= 1'b0;
      digital_resp <= RESP_OFF;
      digital_select_req <= 1'b0;
    end else begin
      analog_filter_en <= ctrl_word[CTRL_FILT_BIT] & ctrl_word[CTRL_ANA_BIT];
      digital_resp <= ctrl_word[CTRL_FILT_BIT] ? ctrl_word[CTRL_RESP_LSB +: 2] : RESP_OFF;
      digital_select_req <= sel_req_set;
    end
  end

  // Setting entries: staged values commit on confirm; cancel wins if both are set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ivl_entry <= IVL_RESET_MS;
      ivl_active <= IVL_RESET_MS;
      dly_entry <= DLY_RESET_MS;
      dly_active <= DLY_RESET_MS;
      ivl_err_set <= 1'b0;
    end else begin
      ivl_err_set <= 1'b0;
      if (wr_fire && wr_addr == REG_IVL_ENTRY) begin
        ivl_entry <= (ivl_entry & ~wmask[CNT_W-1:0]) | wr_masked[CNT_W-1:0];
      end
      if (wr_fire && wr_addr == REG_DLY_ENTRY) begin
        dly_entry <= (dly_entry & ~wmask[CNT_W-1:0]) | wr_masked[CNT_W-1:0];
      end
      if (cmd_bits[CMD_IVL_CANCEL]) begin
        ivl_entry <= ivl_active;
      end else if (cmd_bits[CMD_IVL_OK]) begin
        if (ivl_entry < IVL_MIN_MS) begin
          ivl_err_set <= 1'b1;
        end else if (ivl_entry <= IVL_MAX_MS) begin
          ivl_active <= ivl_entry;
        end
      end
      if (cmd_bits[CMD_DLY_CANCEL]) begin
        dly_entry <= dly_active;
      end else if (cmd_bits[CMD_DLY_OK] && dly_entry <= DLY_MAX_MS) begin
        dly_active <= dly_entry;
      end
    end
  end

  // Millisecond tick from the system clock.
  assign tick = tick_div == TW'(TICK_CYCLES_P - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_div <= '0;
    end else begin
      tick_div <= tick ? '0 : tick_div + TW'(1);
    end
  end

  // External pin: two flops first, the edge detector only looks at the second.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_sync1 <= 1'b1;
      ext_sync2 <= 1'b1;
      ext_prev <= 1'b1;
    end else begin
      ext_sync1 <= ext_trig_in;
      ext_sync2 <= ext_sync1;
      ext_prev <= ext_sync2;
    end
  end
  assign ext_fall = ext_prev & ~ext_sync2;

  // Trigger qualification; manual keys bypass the source but not a disabled source.
  always_comb begin
    src_evt = 1'b0;
    case (src)
      SRC_EXTERNAL: src_evt = ext_fall;
      SRC_TALK: src_evt = cmd_bits[CMD_TALK];
      SRC_GET: src_evt = cmd_bits[CMD_GET];
      SRC_EXEC: src_evt = cmd_bits[CMD_EXEC];
      default: src_evt = 1'b0;
    endcase
  end
  assign trig = (src != SRC_DISABLED)
              & (src_evt | cmd_bits[CMD_MANUAL] | cmd_bits[CMD_BUS_MANUAL]);
  assign overrun_set = one_shot & trig & (state != SEQ_IDLE);

  // Start a reading after the delay, or when the interval expires in multiple mode.
  always_comb begin
    start_now = 1'b0;
    case (state)
      SEQ_IDLE: start_now = trig && dly_active == '0;
      SEQ_DELAY: start_now = dly_cnt == '0;
      SEQ_INTERVAL: start_now = ivl_cnt == '0 && !one_shot && !src_chg;
      default: start_now = 1'b0;
    endcase
  end

  // Reading sequence; triggers while busy are ignored, so a reading is never cut short.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SEQ_IDLE;
      dly_cnt <= '0;
    end else begin
      case (state)
        SEQ_IDLE: begin
          if (start_now) begin
            state <= SEQ_MEASURE;
          end else if (trig) begin
            state <= SEQ_DELAY;
            dly_cnt <= dly_active + CNT_W'(1);  // The first tick is only a partial one.
          end
        end
        SEQ_DELAY: begin
          if (start_now) begin
            state <= SEQ_MEASURE;
          end else if (tick) begin
            dly_cnt <= dly_cnt - CNT_W'(1);
          end
        end
        SEQ_MEASURE: begin
          if (reading_done) begin
            state <= one_shot ? SEQ_IDLE : SEQ_INTERVAL;
          end
        end
        SEQ_INTERVAL: begin
          if (start_now) begin
            state <= SEQ_MEASURE;
          end else if (one_shot || src_chg) begin
            state <= SEQ_IDLE;
          end
        end
        default: state <= SEQ_IDLE;
      endcase
    end
  end

  // Interval runs from one reading start to the next, so reading time is included.
  // One tick more is loaded so that the spacing never falls short of the setting.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ivl_cnt <= '0;
    end else if (start_now) begin
      ivl_cnt <= ivl_active + CNT_W'(1);
    end else if (tick && ivl_cnt != '0) begin
      ivl_cnt <= ivl_cnt - CNT_W'(1);
    end
  end

  // Measurement path strobes and completion output.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reading_start <= 1'b0;
      meter_complete_out <= 1'b0;
      buffer_write <= 1'b0;
    end else begin
      reading_start <= start_now;
      if (start_now) begin
        meter_complete_out <= 1'b1;
      end else if (state == SEQ_MEASURE && reading_done) begin
        meter_complete_out <= 1'b0;
      end
      buffer_write <= state == SEQ_MEASURE && reading_done && !one_shot;
    end
  end

  // Flash timer for the waiting lamp.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_cnt <= '0;
      flash_phase <= 1'b0;
    end else if (tick) begin
      if (flash_cnt == FLASH_HALF_MS - CNT_W'(1)) begin
        flash_cnt <= '0;
        flash_phase <= ~flash_phase;
      end else begin
        flash_cnt <= flash_cnt + CNT_W'(1);
      end
    end
  end

  // Indicators: steady in one-shot, flashing while multiple waits for its first trigger.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waiting_indicator <= 1'b1;
      triggered_indicator <= 1'b0;
    end else begin
      waiting_indicator <= one_shot | (state == SEQ_IDLE & flash_phase);
      if (trig && state == SEQ_IDLE) begin
        triggered_indicator <= 1'b1;
      end else if (state == SEQ_MEASURE && reading_done) begin
        triggered_indicator <= 1'b0;
      end
    end
  end

  // Sticky errors and requests; a set in the clearing cycle survives.
  assign sticky_set = {sel_req_set, ivl_err_set, overrun_set};
  assign sticky_clr = (wr_fire && wr_addr == REG_STATUS) ? wr_masked[ST_STICKY_LSB +: STICKY_N] : '0;
  for (genvar i = 0; i < STICKY_N; i++) begin : g_sticky
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sticky[i] <= 1'b0;
      end else begin
        sticky[i] <= sticky_set[i] | (sticky[i] & ~sticky_clr[i]);
      end
    end
  end

  // Read decode.
  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    case (araddr)
      REG_CTRL: rd_word = DATA_W'(ctrl_word);
      REG_IVL_ENTRY: rd_word = DATA_W'(ivl_entry);
      REG_DLY_ENTRY: rd_word = DATA_W'(dly_entry);
      REG_CMD: rd_word = '0;
      REG_IVL_ACTIVE: rd_word = DATA_W'(ivl_active);
      REG_DLY_ACTIVE: rd_word = DATA_W'(dly_active);
      REG_STATUS: begin
        rd_word[ST_BUSY] = state != SEQ_IDLE;
        rd_word[ST_WAIT] = waiting_indicator;
        rd_word[ST_TRIGGERED] = triggered_indicator;
        rd_word[ST_STICKY_LSB +: STICKY_N] = sticky;
        rd_word[ST_ANA] = analog_filter_en;
        rd_word[ST_RESP_LSB +: 2] = digital_resp;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // Read channel handshake; one read at a time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [pkg/trigger_sequencer_pkg.sv]
// Constants and types shared by the trigger sequencer design.
// Contract
// - Multiple mode spaces readings by repeat interval.
// - One-shot mode ignores the repeat interval.
// - Interval also paces buffer writes in multiple.
// - Interval 10 ms to 999.999 s, resets 0.25 s.
// - Interval below 10 ms rejected, error raised.
// - Wait programmed delay after trigger before reading.
// - Delay 0 to 999.999 s, resets to zero.
// - Entries commit on confirm, cancel restores old.
// - One-shot waiting lamp steady, triggered lamp per reading.
// - Waiting lamp flashes after switch to multiple.
// - External trigger recognised on falling edge.
// - External one-shot takes one reading per pulse.
// - Completion pulse output for each processed reading.
// - One-shot trigger while busy raises overrun.
// - Overrun never aborts the reading in progress.
// - Bus group trigger, talk and execute trigger.
// - Master filter off disables both filters.
// - Master filter on applies stored filter selections.
// - Filter on with both off requests digital selection.
// - Digital response is off, fast, medium, slow.
// - One-shot needs trigger each; multiple runs forever (code returns to idle on a source change written during the interval wait).
// - Manual triggers always accepted unless source disabled.
`default_nettype none
package trigger_sequencer_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 20;
  localparam int CTRL_W = 8;
  // Register byte addresses.
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_IVL_ENTRY = 8'h04;
  localparam logic [ADDR_W-1:0] REG_DLY_ENTRY = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_IVL_ACTIVE = 8'h10;
  localparam logic [ADDR_W-1:0] REG_DLY_ACTIVE = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control word fields and reset value (one-shot, manual source, filters off).
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_SRC_LSB = 1;
  localparam int CTRL_FILT_BIT = 4;
  localparam int CTRL_ANA_BIT = 5;
  localparam int CTRL_RESP_LSB = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h04;
  // Command bits; each acts once per write and reads back as zero.
  localparam int CMD_IVL_OK = 0;
  localparam int CMD_IVL_CANCEL = 1;
  localparam int CMD_DLY_OK = 2;
  localparam int CMD_DLY_CANCEL = 3;
  localparam int CMD_MANUAL = 4;
  localparam int CMD_BUS_MANUAL = 5;
  localparam int CMD_GET = 6;
  localparam int CMD_TALK = 7;
  localparam int CMD_EXEC = 8;
  // Status fields; sticky bits are contiguous from ST_STICKY_LSB.
  localparam int ST_BUSY = 0;
  localparam int ST_WAIT = 1;
  localparam int ST_TRIGGERED = 2;
  localparam int ST_STICKY_LSB = 3;
  localparam int STICKY_N = 3;
  localparam int ST_ANA = 6;
  localparam int ST_RESP_LSB = 7;
  // Times in milliseconds and the tick derived from the clock.
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 32'h000f_4240;  // 1 ms.
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] IVL_MIN_MS = 20'h0_000a;
  localparam logic [CNT_W-1:0] IVL_MAX_MS = 20'hf_423f;
  localparam logic [CNT_W-1:0] IVL_RESET_MS = 20'h0_00fa;
  localparam logic [CNT_W-1:0] DLY_MAX_MS = 20'hf_423f;
  localparam logic [CNT_W-1:0] DLY_RESET_MS = 20'h0_0000;
  localparam logic [CNT_W-1:0] FLASH_HALF_MS = 20'h0_00fa;
  typedef enum logic [2:0] {
    SRC_DISABLED = 3'h0,
    SRC_EXTERNAL = 3'h1,
    SRC_MANUAL = 3'h2,
    SRC_TALK = 3'h3,
    SRC_GET = 3'h4,
    SRC_EXEC = 3'h5
  } trig_src_e;
  typedef enum logic [1:0] {
    RESP_OFF = 2'h0,
    RESP_FAST = 2'h1,
    RESP_MEDIUM = 2'h2,
    RESP_SLOW = 2'h3
  } filt_resp_e;
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_DELAY = 4'h2,
    SEQ_MEASURE = 4'h4,
    SEQ_INTERVAL = 4'h8
  } seq_state_e;
endpackage
`default_nettype wire

// [test/meter_partner.sv]
// Far-side model: external trigger source and measurement path.
`default_nettype none
module meter_partner (
  input wire logic aclk,
  input wire logic reading_start,
  input wire logic meter_complete_out,
  output logic ext_trig_in,
  output logic reading_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int lat = 5;
  int left = 0;
  int readings = 0;
  int completes = 0;
  logic mc_q = 1'b0;
  initial ext_trig_in = 1'b1;
  // A reading ends lat cycles after start; a long lat provokes overrun.
  always @(posedge aclk) begin
    if (reading_start) begin
      readings++;
      left <= lat;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end
  assign reading_done = (left == 1);
  // Completion pulses are counted as the receiving equipment would.
  always @(posedge aclk) begin
    if (meter_complete_out && !mc_q) completes++;
    mc_q <= meter_complete_out;
  end
  // Idle high, a low pulse of three cycles, trigger on its falling edge.
  task automatic pulse();
    @(posedge aclk);
    ext_trig_in <= 1'b0;
    repeat (3) @(posedge aclk);
    ext_trig_in <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [test/trigger_sequencer_asserts.sv]
// Checker of the trigger sequencer port behaviour.
`default_nettype none
module trigger_sequencer_asserts (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus responses.
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Reading sequence.
  input wire logic reading_start,
  input wire logic reading_done,
  input wire logic meter_complete_out,
  input wire logic buffer_write,
  input wire logic triggered_indicator,
  input wire logic digital_select_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Responses must stand until the master takes them.
  a_b_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_r_data_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  // Start and completion output belong together.
  a_start_pulse: assert property (reading_start |=> !reading_start)
    else $error("start longer than one cycle");
  a_start_complete: assert property (reading_start |-> ##[0:1] meter_complete_out)
    else $error("no completion pulse for reading");
  a_complete_holds: assert property (meter_complete_out && !reading_done |=> meter_complete_out)
    else $error("reading cut short");
  a_done_ends: assert property (meter_complete_out && reading_done |=> !meter_complete_out || reading_start)
    else $error("completion pulse not ended");
  a_trig_clear: assert property (triggered_indicator && meter_complete_out && reading_done |=> !triggered_indicator)
    else $error("triggered lamp not cleared");
  // Buffer writes follow a finished reading only; buffer write and select request last one cycle.
  a_buf_cause: assert property (buffer_write |-> $past(reading_done && meter_complete_out))
    else $error("buffer write without reading");
  a_buf_pulse: assert property (buffer_write |=> !buffer_write)
    else $error("buffer write too long");
  a_sel_pulse: assert property (digital_select_req |=> !digital_select_req)
    else $error("select request too long");
  // Main scenarios.
  c_start: cover property (reading_start);
  c_buffer: cover property (buffer_write);
  c_select: cover property (digital_select_req);
endmodule
bind trigger_sequencer trigger_sequencer_asserts i_chk (
  .aclk(aclk), .aresetn(aresetn), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .reading_start(reading_start),
  .reading_done(reading_done), .meter_complete_out(meter_complete_out), .buffer_write(buffer_write),
  .triggered_indicator(triggered_indicator), .digital_select_req(digital_select_req)
);
`default_nettype wire

// [test/trigger_sequencer_tb.sv]
// Self-checking testbench of the trigger sequencer.
`default_nettype none
module trigger_sequencer_tb
  import trigger_sequencer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, digital_resp;
  logic ext_trig_in, reading_done, reading_start, meter_complete_out, buffer_write;
  logic waiting_indicator, triggered_indicator, analog_filter_en, digital_select_req;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_buf = 0;
  int rb, cb;
  // Short tick keeps millisecond figures at ten cycles.
  trigger_sequencer #(.TICK_CYCLES_P(10)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .ext_trig_in(ext_trig_in), .reading_done(reading_done),
    .reading_start(reading_start), .meter_complete_out(meter_complete_out), .buffer_write(buffer_write),
    .waiting_indicator(waiting_indicator), .triggered_indicator(triggered_indicator),
    .analog_filter_en(analog_filter_en), .digital_resp(digital_resp), .digital_select_req(digital_select_req)
  );
  meter_partner i_far (
    .aclk(aclk), .reading_start(reading_start), .meter_complete_out(meter_complete_out),
    .ext_trig_in(ext_trig_in), .reading_done(reading_done)
  );
  // Clock; the cycle counter cuts a hang short.
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (buffer_write) n_buf++;
    if (cycles == 40000) begin
      mismatches++;
      $display("Error %0t: timeout", $time);
      close_out();
    end
  end
  task automatic close_out();
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Bus write; address and data are released each when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
        break;
      end
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
                     input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        chk(rdata & m, e);
        chk(32'(rresp), 32'(er));
        break;
      end
    end
  endtask
  task automatic cmd(input int b);
    wr(REG_CMD, 32'h0000_0001 << b);
  endtask
  task automatic wait_start(output int c);
    c = 0;
    while (reading_start !== 1'b1 && c < 300) begin
      @(negedge aclk);
      c++;
    end
  endtask
  task automatic mark();
    rb = i_far.readings;
    cb = i_far.completes;
  endtask
  task automatic cnt_reads(input int lim, input int n);
    repeat (lim) @(negedge aclk);
    chk(32'(i_far.readings - rb), 32'(n));
    chk(32'(i_far.completes - cb), 32'(n));
  endtask
  task automatic t_reset();
    rdc(REG_CTRL, 32'h0000_0004);
    rdc(REG_IVL_ACTIVE, 32'h0000_00fa);
    rdc(REG_DLY_ACTIVE, 32'h0000_0000);
    chk(32'(waiting_indicator), 32'h0000_0001);
    wr(8'h10, 32'h0000_0005, RESP_SLVERR);
    rdc(REG_IVL_ACTIVE, 32'h0000_00fa);
    rdc(8'h1c, 32'h0000_0000, '1, RESP_SLVERR);
  endtask
  task automatic t_interval();
    wr(REG_IVL_ENTRY, 32'h0000_0009);
    cmd(CMD_IVL_OK);
    rdc(REG_IVL_ACTIVE, 32'h0000_00fa);
    rdc(REG_STATUS, 32'h0000_0010, 32'h0000_0010);
    wr(REG_STATUS, 32'h0000_0010);
    rdc(REG_STATUS, 32'h0000_0000, 32'h0000_0010);
    wr(REG_IVL_ENTRY, 32'h000f_423f);
    cmd(CMD_IVL_OK);
    rdc(REG_IVL_ACTIVE, 32'h000f_423f);
    wr(REG_IVL_ENTRY, 32'h0000_000a);
    cmd(CMD_IVL_OK);
    rdc(REG_IVL_ACTIVE, 32'h0000_000a);
    wr(REG_IVL_ENTRY, 32'h0000_0014);
    cmd(CMD_IVL_CANCEL);
    rdc(REG_IVL_ACTIVE, 32'h0000_000a);
  endtask
  task automatic t_delay();
    int c;
    wr(REG_DLY_ENTRY, 32'h0000_0003);
    cmd(CMD_DLY_OK);
    rdc(REG_DLY_ACTIVE, 32'h0000_0003);
    cmd(CMD_MANUAL);
    wait_start(c);
    chk(32'(c >= 25 && c <= 45), 32'h0000_0001);
    @(negedge aclk);
    chk(32'({triggered_indicator, meter_complete_out}), 32'h0000_0003);
    repeat (10) @(negedge aclk);
    chk(32'({triggered_indicator, meter_complete_out}), 32'h0000_0000);
    wr(REG_DLY_ENTRY, 32'h0000_0000);
    cmd(CMD_DLY_OK);
    wr(REG_DLY_ENTRY, 32'h0000_0007);
    cmd(CMD_DLY_CANCEL);
    rdc(REG_DLY_ACTIVE, 32'h0000_0000);
  endtask
  task automatic t_overrun();
    i_far.lat = 40;
    mark();
    cmd(CMD_MANUAL);
    cmd(CMD_MANUAL);
    cnt_reads(60, 1);
    rdc(REG_STATUS, 32'h0000_0008, 32'h0000_0008);
    wr(REG_STATUS, 32'h0000_0008);
    i_far.lat = 5;
  endtask
  task automatic t_sources();
    int bits[3] = '{CMD_TALK, CMD_GET, CMD_EXEC};
    for (int i = 0; i < 3; i++) begin
      wr(REG_CTRL, 32'((3 + i) << 1));
      mark();
      cmd(bits[i]);
      cnt_reads(25, 1);
      mark();
      cmd(CMD_BUS_MANUAL);
      cnt_reads(25, 1);
    end
    wr(REG_CTRL, 32'h0000_0000);
    mark();
    cmd(CMD_MANUAL);
    cmd(CMD_BUS_MANUAL);
    cnt_reads(25, 0);
  endtask
  task automatic t_external();
    wr(REG_CTRL, 32'h0000_0002);
    repeat (2) begin
      mark();
      i_far.pulse();
      cnt_reads(30, 1);
    end
    wr(REG_CTRL, 32'h0000_0004);
    mark();
    i_far.pulse();
    cnt_reads(30, 0);
  endtask
  task automatic t_filters();
    for (int r = 0; r < 4; r++) begin
      wr(REG_CTRL, 32'h0000_0034 | 32'(r << 6));
      repeat (2) @(negedge aclk);
      chk(32'({analog_filter_en, digital_resp}), 32'(4 + r));
    end
    wr(REG_CTRL, 32'h0000_00e4);
    repeat (2) @(negedge aclk);
    chk(32'({analog_filter_en, digital_resp}), 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0014);
    @(negedge aclk);
    chk(32'(digital_select_req), 32'h0000_0001);
    rdc(REG_STATUS, 32'h0000_0020, 32'h0000_0020);
    chk(32'({analog_filter_en, digital_resp}), 32'h0000_0000);
  endtask
  task automatic t_multiple();
    int c, b0, r0;
    logic w;
    wr(REG_CTRL, 32'h0000_0005);
    w = waiting_indicator;
    c = 0;
    while (waiting_indicator === w && c < 2700) begin
      @(negedge aclk);
      c++;
    end
    chk(32'(c < 2700), 32'h0000_0001);
    b0 = n_buf;
    r0 = i_far.readings;
    cmd(CMD_MANUAL);
    wait_start(c);
    @(negedge aclk);
    wait_start(c);
    chk(32'(c >= 90 && c <= 115), 32'h0000_0001);
    chk(32'(waiting_indicator), 32'h0000_0000);
    cmd(CMD_MANUAL);
    rdc(REG_STATUS, 32'h0000_0000, 32'h0000_0008);
    wr(REG_CTRL, 32'h0000_0004);
    repeat (30) @(negedge aclk);
    chk(32'(n_buf - b0), 32'(i_far.readings - r0));
    mark();
    cnt_reads(300, 0);
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_interval();
    t_delay();
    t_overrun();
    t_sources();
    t_external();
    t_filters();
    t_multiple();
    close_out();
  end
endmodule
`default_nettype wire
